// [core/sensor_parameter_bank_pkg.sv]
// Offsets, reset values, field layout and carrier types of the sensor parameter bank
package sensor_parameter_bank_pkg;

    localparam int PARAM_DEPTH = 32;

    // Parameter offsets
    localparam logic [4:0] OFS_BUS_ADDR      = 5'h00;
    localparam logic [4:0] OFS_CHAN_LIST     = 5'h01;
    localparam logic [4:0] OFS_EMIT_12       = 5'h02;
    localparam logic [4:0] OFS_EMIT_3        = 5'h03;
    localparam logic [4:0] OFS_RSVD_04       = 5'h04;
    localparam logic [4:0] OFS_PROX_ALIGN    = 5'h05;
    localparam logic [4:0] OFS_AMB_ALIGN     = 5'h06;
    localparam logic [4:0] OFS_AMB_HISTORY   = 5'h19;
    localparam logic [4:0] OFS_CONV_OFFSET   = 5'h1A;
    localparam logic [4:0] OFS_RSVD_1B       = 5'h1B;
    localparam logic [4:0] OFS_EMIT_RECOVERY = 5'h1C;
    localparam logic [4:0] OFS_IR_COUNTER    = 5'h1D;
    localparam logic [4:0] OFS_IR_GAIN       = 5'h1E;
    localparam logic [4:0] OFS_IR_MISC       = 5'h1F;

    // Values after reset
    localparam logic [7:0] RST_BUS_ADDR    = 8'h00;
    localparam logic [7:0] RST_CHAN_LIST   = 8'h00;
    localparam logic [7:0] RST_EMIT_12     = 8'h21;
    localparam logic [7:0] RST_EMIT_3      = 8'h04;
    localparam logic [7:0] RST_ALIGN       = 8'h00;
    localparam logic [7:0] RST_OTHER       = 8'h00;
    // Arbitrary power-up answer address until the first address change
    localparam logic [7:0] RST_ACTIVE_ADDR = 8'h00;

    // Field positions
    localparam int EN_AUX_BIT     = 6;
    localparam int EN_IR_BIT      = 5;
    localparam int EN_VIS_BIT     = 4;
    localparam int EN_P3_BIT      = 2;
    localparam int EN_P2_BIT      = 1;
    localparam int EN_P1_BIT      = 0;
    localparam int EMIT_ONE_LSB   = 0;
    localparam int EMIT_TWO_LSB   = 4;
    localparam int EMIT_THREE_LSB = 0;
    localparam int ALIGN_P3_BIT   = 6;
    localparam int ALIGN_P2_BIT   = 5;
    localparam int ALIGN_P1_BIT   = 4;
    localparam int ALIGN_VIS_BIT  = 5;
    localparam int ALIGN_IR_BIT   = 4;

    // Writable bits; reserved bits stay zero
    localparam logic [7:0] MASK_CHAN_LIST  = 8'h77;
    localparam logic [7:0] MASK_EMIT_12    = 8'h77;
    localparam logic [7:0] MASK_EMIT_3     = 8'h07;
    localparam logic [7:0] MASK_PROX_ALIGN = 8'h70;
    localparam logic [7:0] MASK_AMB_ALIGN  = 8'h30;
    localparam logic [7:0] MASK_IR_COUNTER = 8'h70;
    localparam logic [7:0] MASK_IR_MISC    = 8'h20;
    localparam logic [7:0] MASK_NONE       = 8'h00;
    localparam logic [7:0] MASK_ALL        = 8'hFF;

    typedef enum logic [2:0] {
        CHAN_PROX_ONE   = 3'h0,
        CHAN_PROX_TWO   = 3'h1,
        CHAN_PROX_THREE = 3'h2,
        CHAN_VISIBLE    = 3'h3,
        CHAN_INFRARED   = 3'h4,
        CHAN_AUX        = 3'h5
    } conv_chan_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [4:0] offset;
        logic [7:0] wdata;
    } param_cmd_t;

    typedef struct packed {
        logic       valid;
        conv_chan_t chan;
        logic [16:0] data;
    } conv_sample_t;

    function automatic logic [7:0] param_reset(input logic [4:0] ofs);
        case (ofs)
            OFS_BUS_ADDR:   param_reset = RST_BUS_ADDR;
            OFS_CHAN_LIST:  param_reset = RST_CHAN_LIST;
            OFS_EMIT_12:    param_reset = RST_EMIT_12;
            OFS_EMIT_3:     param_reset = RST_EMIT_3;
            OFS_PROX_ALIGN: param_reset = RST_ALIGN;
            OFS_AMB_ALIGN:  param_reset = RST_ALIGN;
            default:        param_reset = RST_OTHER;
        endcase
    endfunction

    function automatic logic [7:0] param_wmask(input logic [4:0] ofs);
        case (ofs)
            OFS_CHAN_LIST:  param_wmask = MASK_CHAN_LIST;
            OFS_EMIT_12:    param_wmask = MASK_EMIT_12;
            OFS_EMIT_3:     param_wmask = MASK_EMIT_3;
            OFS_RSVD_04:    param_wmask = MASK_NONE;
            OFS_PROX_ALIGN: param_wmask = MASK_PROX_ALIGN;
            OFS_AMB_ALIGN:  param_wmask = MASK_AMB_ALIGN;
            OFS_RSVD_1B:    param_wmask = MASK_NONE;
            OFS_IR_COUNTER: param_wmask = MASK_IR_COUNTER;
            OFS_IR_MISC:    param_wmask = MASK_IR_MISC;
            default:        param_wmask = MASK_ALL;
        endcase
    endfunction

endpackage

// [core/result_aligner.sv]
// Picks 16 of the 17 converter bits for one sample and registers the result
`timescale 1ns/1ps
module result_aligner (
    input  wire logic                                core_clk_i,    // System clock
    input  wire logic                                rst_i,         // Async reset, high
    input  sensor_parameter_bank_pkg::conv_sample_t  sample_i,      // Converter sample
    input  wire logic                                low_align_i,   // Report low 16 bits
    output logic                                     valid_o,       // Result strobe
    output sensor_parameter_bank_pkg::conv_chan_t    chan_o,        // Result channel
    output logic [15:0]                              data_o         // Aligned result
);
    logic                                  valid_r;
    logic                                  valid_nxt;
    sensor_parameter_bank_pkg::conv_chan_t chan_r;
    sensor_parameter_bank_pkg::conv_chan_t chan_nxt;
    logic [15:0]                           data_r;
    logic [15:0]                           data_nxt;

    always_comb begin
        valid_nxt = sample_i.valid;
        chan_nxt  = chan_r;
        data_nxt  = data_r;
        if (sample_i.valid) begin
            chan_nxt = sample_i.chan;
            // Low alignment drops the top bit; high alignment drops the lsb
            data_nxt = low_align_i ? sample_i.data[15:0] : sample_i.data[16:1];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_r <= 1'b0;
            chan_r  <= sensor_parameter_bank_pkg::CHAN_PROX_ONE;
            data_r  <= 16'h0000;
        end else begin
            valid_r <= valid_nxt;
            chan_r  <= chan_nxt;
            data_r  <= data_nxt;
        end
    end

    assign valid_o = valid_r;
    assign chan_o  = chan_r;
    assign data_o  = data_r;
endmodule

// [core/sensor_parameter_bank.sv]
// Parameter memory of the light and proximity sensor, reached by parameter commands
`timescale 1ns/1ps
// Functional notes
// - A written bus address is only stored and becomes the answer address on an address change.
// - Channel list bits 6, 5 and 4 enable the auxiliary, infrared and visible ambient channels.
// - Channel list bits 2, 1 and 0 enable proximity channels three, two and one.
// - Each bit of a three-bit emitter select drives one emitter, lowest bit the first one.
// - Channel two select is bits 6:4 and channel one bits 2:0 of one entry, channel three next.
// - After reset channel one drives emitter one, two drives two and three drives three.
// - Proximity alignment bits 6, 5, 4 pick low 16 result bits for channels three, two, one.
// - Ambient alignment bit 5 picks the low 16 bits for the visible measurement.
// - Ambient alignment bit 4 picks the low 16 bits for the infrared measurement.
// - Bus address, channel list and both alignment entries read zero after reset.
// - Entries are reached only through parameter read and write commands.
module sensor_parameter_bank (
    input  wire logic                                core_clk_i,               // 40 MHz clock
    input  wire logic                                rst_i,                    // Async reset
    input  sensor_parameter_bank_pkg::param_cmd_t    param_cmd_i,              // Read/write cmd
    input  wire logic                                address_change_command_i, // Adopt address
    input  wire logic                                meas_active_i,            // Measuring
    input  sensor_parameter_bank_pkg::conv_chan_t    meas_chan_i,              // Measured chan
    input  sensor_parameter_bank_pkg::conv_sample_t  conv_sample_i,            // Raw sample
    output logic                                     rsp_valid_o,              // Cmd done
    output logic [7:0]                               rsp_data_o,               // Read data
    output logic [7:0]                               active_bus_address_o,     // Live address
    output logic                                     aux_enable_o,             // Aux enabled
    output logic                                     infrared_ambient_enable_o,// IR enabled
    output logic                                     visible_ambient_enable_o, // Vis enabled
    output logic                                     proximity_three_enable_o, // Prox 3
    output logic                                     proximity_two_enable_o,   // Prox 2
    output logic                                     proximity_one_enable_o,   // Prox 1
    output logic [2:0]                               infrared_emitter_o,       // Emitter drives
    output logic                                     result_valid_o,           // Result strobe
    output sensor_parameter_bank_pkg::conv_chan_t    result_chan_o,            // Result chan
    output logic [15:0]                              result_data_o             // 16-bit result
);
    localparam int DEPTH = sensor_parameter_bank_pkg::PARAM_DEPTH;

    logic [7:0] param_r   [DEPTH];
    logic [7:0] param_nxt [DEPTH];
    logic       rsp_valid_r;
    logic       rsp_valid_nxt;
    logic [7:0] rsp_data_r;
    logic [7:0] rsp_data_nxt;
    logic [7:0] active_addr_r;
    logic [7:0] active_addr_nxt;
    logic [2:0] emitter_r;
    logic [2:0] emitter_nxt;
    logic       low_align;

    // Alignment bit that governs a channel; auxiliary has none and stays high aligned
    function automatic logic align_for(input sensor_parameter_bank_pkg::conv_chan_t ch,
                                       input logic [7:0] prox,
                                       input logic [7:0] amb);
        case (ch)
            sensor_parameter_bank_pkg::CHAN_PROX_ONE:
                align_for = prox[sensor_parameter_bank_pkg::ALIGN_P1_BIT];
            sensor_parameter_bank_pkg::CHAN_PROX_TWO:
                align_for = prox[sensor_parameter_bank_pkg::ALIGN_P2_BIT];
            sensor_parameter_bank_pkg::CHAN_PROX_THREE:
                align_for = prox[sensor_parameter_bank_pkg::ALIGN_P3_BIT];
            sensor_parameter_bank_pkg::CHAN_VISIBLE:
                align_for = amb[sensor_parameter_bank_pkg::ALIGN_VIS_BIT];
            sensor_parameter_bank_pkg::CHAN_INFRARED:
                align_for = amb[sensor_parameter_bank_pkg::ALIGN_IR_BIT];
            default:
                align_for = 1'b0;
        endcase
    endfunction

    // Parameter store; reserved bits are masked so they always read zero
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            param_nxt[i] = param_r[i];
        end
        if (param_cmd_i.valid && param_cmd_i.write) begin
            param_nxt[param_cmd_i.offset] =
                param_cmd_i.wdata & sensor_parameter_bank_pkg::param_wmask(param_cmd_i.offset);
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                param_r[i] <= sensor_parameter_bank_pkg::param_reset(5'(i));
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                param_r[i] <= param_nxt[i];
            end
        end
    end

    // Command answer: one cycle after the command, for reads and writes alike
    always_comb begin
        rsp_valid_nxt = param_cmd_i.valid;
        rsp_data_nxt  = rsp_data_r;
        if (param_cmd_i.valid && !param_cmd_i.write) begin
            rsp_data_nxt = param_r[param_cmd_i.offset];
        end
    end

    // Address register only follows the stored entry on the change command
    always_comb begin
        active_addr_nxt = active_addr_r;
        if (address_change_command_i) begin
            active_addr_nxt = param_r[sensor_parameter_bank_pkg::OFS_BUS_ADDR];
        end
    end

    // Emitters drive only while a proximity measurement runs
    always_comb begin
        emitter_nxt = 3'h0;
        if (meas_active_i) begin
            case (meas_chan_i)
                sensor_parameter_bank_pkg::CHAN_PROX_ONE:
                    emitter_nxt = param_r[sensor_parameter_bank_pkg::OFS_EMIT_12]
                        [sensor_parameter_bank_pkg::EMIT_ONE_LSB +: 3];
                sensor_parameter_bank_pkg::CHAN_PROX_TWO:
                    emitter_nxt = param_r[sensor_parameter_bank_pkg::OFS_EMIT_12]
                        [sensor_parameter_bank_pkg::EMIT_TWO_LSB +: 3];
                sensor_parameter_bank_pkg::CHAN_PROX_THREE:
                    emitter_nxt = param_r[sensor_parameter_bank_pkg::OFS_EMIT_3]
                        [sensor_parameter_bank_pkg::EMIT_THREE_LSB +: 3];
                default:
                    emitter_nxt = 3'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_valid_r   <= 1'b0;
            rsp_data_r    <= 8'h00;
            active_addr_r <= sensor_parameter_bank_pkg::RST_ACTIVE_ADDR;
            emitter_r     <= 3'h0;
        end else begin
            rsp_valid_r   <= rsp_valid_nxt;
            rsp_data_r    <= rsp_data_nxt;
            active_addr_r <= active_addr_nxt;
            emitter_r     <= emitter_nxt;
        end
    end

    assign low_align = align_for(conv_sample_i.chan,
                                 param_r[sensor_parameter_bank_pkg::OFS_PROX_ALIGN],
                                 param_r[sensor_parameter_bank_pkg::OFS_AMB_ALIGN]);

    result_aligner u_aligner (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .sample_i    (conv_sample_i),
        .low_align_i (low_align),
        .valid_o     (result_valid_o),
        .chan_o      (result_chan_o),
        .data_o      (result_data_o)
    );

    assign rsp_valid_o          = rsp_valid_r;
    assign rsp_data_o           = rsp_data_r;
    assign active_bus_address_o = active_addr_r;
    assign infrared_emitter_o   = emitter_r;
    // Enables come straight from the channel list flip-flops
    assign aux_enable_o              = param_r[1][sensor_parameter_bank_pkg::EN_AUX_BIT];
    assign infrared_ambient_enable_o = param_r[1][sensor_parameter_bank_pkg::EN_IR_BIT];
    assign visible_ambient_enable_o  = param_r[1][sensor_parameter_bank_pkg::EN_VIS_BIT];
    assign proximity_three_enable_o  = param_r[1][sensor_parameter_bank_pkg::EN_P3_BIT];
    assign proximity_two_enable_o    = param_r[1][sensor_parameter_bank_pkg::EN_P2_BIT];
    assign proximity_one_enable_o    = param_r[1][sensor_parameter_bank_pkg::EN_P1_BIT];

    // Checks; shadows of host writes are kept apart from the store so the checks do not
    // simply mirror it
    logic       wr_seen_r;
    logic [7:0] addr_wr_r;
    logic [7:0] emit12_wr_r;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_seen_r   <= 1'b0;
            addr_wr_r   <= sensor_parameter_bank_pkg::RST_BUS_ADDR;
            emit12_wr_r <= sensor_parameter_bank_pkg::RST_EMIT_12;
        end else if (param_cmd_i.valid && param_cmd_i.write) begin
            wr_seen_r <= 1'b1;
            if (param_cmd_i.offset == sensor_parameter_bank_pkg::OFS_BUS_ADDR) begin
                addr_wr_r <= param_cmd_i.wdata;
            end
            if (param_cmd_i.offset == sensor_parameter_bank_pkg::OFS_EMIT_12) begin
                emit12_wr_r <= param_cmd_i.wdata;
            end
        end
    end

    wire wr_cmd = param_cmd_i.valid && param_cmd_i.write;
    wire rd_cmd = param_cmd_i.valid && !param_cmd_i.write;

    property p_addr_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        !address_change_command_i |=> $stable(active_bus_address_o);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved without change");

    property p_addr_take;
        @(posedge core_clk_i) disable iff (rst_i)
        address_change_command_i |=> active_bus_address_o == $past(addr_wr_r);
    endproperty
    a_addr_take: assert property (p_addr_take) else $error("new address not adopted");

    property p_ambient_en;
        @(posedge core_clk_i) disable iff (rst_i)
        (wr_cmd && param_cmd_i.offset == 5'h01) |=>
        {aux_enable_o, infrared_ambient_enable_o, visible_ambient_enable_o}
            == $past(param_cmd_i.wdata[6:4]);
    endproperty
    a_ambient_en: assert property (p_ambient_en) else $error("ambient enables wrong");

    property p_prox_en;
        @(posedge core_clk_i) disable iff (rst_i)
        (wr_cmd && param_cmd_i.offset == 5'h01) |=>
        {proximity_three_enable_o, proximity_two_enable_o, proximity_one_enable_o}
            == $past(param_cmd_i.wdata[2:0]);
    endproperty
    a_prox_en: assert property (p_prox_en) else $error("proximity enables wrong");

    property p_emit_two;
        @(posedge core_clk_i) disable iff (rst_i)
        meas_active_i && meas_chan_i == sensor_parameter_bank_pkg::CHAN_PROX_TWO
        |=> infrared_emitter_o == $past(emit12_wr_r[6:4]);
    endproperty
    a_emit_two: assert property (p_emit_two) else $error("channel two emitters wrong");

    property p_emit_idle;
        @(posedge core_clk_i) disable iff (rst_i)
        !meas_active_i |=> infrared_emitter_o == 3'h0;
    endproperty
    a_emit_idle: assert property (p_emit_idle) else $error("emitter on while idle");

    property p_reset_vals;
        @(posedge core_clk_i) disable iff (rst_i)
        !wr_seen_r |-> param_r[2] == 8'h21 && param_r[3] == 8'h04 && param_r[0] == 8'h00
            && param_r[1] == 8'h00 && param_r[5] == 8'h00 && param_r[6] == 8'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad default");

    property p_align_prox;
        @(posedge core_clk_i) disable iff (rst_i)
        conv_sample_i.valid && conv_sample_i.chan == sensor_parameter_bank_pkg::CHAN_PROX_ONE
        |=> result_data_o == ($past(param_r[5][4]) ? $past(conv_sample_i.data[15:0])
                                                    : $past(conv_sample_i.data[16:1]));
    endproperty
    a_align_prox: assert property (p_align_prox) else $error("prox one alignment wrong");

    property p_align_vis;
        @(posedge core_clk_i) disable iff (rst_i)
        conv_sample_i.valid && conv_sample_i.chan == sensor_parameter_bank_pkg::CHAN_VISIBLE
        |=> result_valid_o && result_data_o == ($past(param_r[6][5])
            ? $past(conv_sample_i.data[15:0]) : $past(conv_sample_i.data[16:1]));
    endproperty
    a_align_vis: assert property (p_align_vis) else $error("visible alignment wrong");

    property p_align_ir;
        @(posedge core_clk_i) disable iff (rst_i)
        conv_sample_i.valid && conv_sample_i.chan == sensor_parameter_bank_pkg::CHAN_INFRARED
        |=> result_data_o == ($past(param_r[6][4]) ? $past(conv_sample_i.data[15:0])
                                                    : $past(conv_sample_i.data[16:1]));
    endproperty
    a_align_ir: assert property (p_align_ir) else $error("infrared alignment wrong");

    property p_read_back;
        @(posedge core_clk_i) disable iff (rst_i)
        wr_cmd ##1 !param_cmd_i.valid
        ##1 (rd_cmd && param_cmd_i.offset == $past(param_cmd_i.offset, 2))
        |=> rsp_valid_o && rsp_data_o == ($past(param_cmd_i.wdata, 3)
            & sensor_parameter_bank_pkg::param_wmask($past(param_cmd_i.offset, 3)));
    endproperty
    a_read_back: assert property (p_read_back) else $error("read-back mismatch");

    c_addr_change: cover property (@(posedge core_clk_i) disable iff (rst_i)
        address_change_command_i ##1 active_bus_address_o != 8'h00);
    c_emit_three: cover property (@(posedge core_clk_i) disable iff (rst_i)
        infrared_emitter_o == 3'h7);
    c_low_align: cover property (@(posedge core_clk_i) disable iff (rst_i)
        conv_sample_i.valid && low_align);
endmodule

// [test/param_host.sv]
// Host model that reaches the parameter entries through read and write commands
`timescale 1ns/1ps
module param_host (
    input  wire logic                              clk_i,       // 40 MHz clock
    input  wire logic                              rsp_valid_i, // Command done
    input  wire logic [7:0]                        rsp_data_i,  // Read data
    output sensor_parameter_bank_pkg::param_cmd_t  cmd_o,       // Parameter command
    output logic                                   addr_chg_o   // Adopt stored address
);
    initial begin
        cmd_o = '0;
        addr_chg_o = 1'b0;
    end

    // Entries have no address of their own; every access is one command
    task automatic xfer(input logic w, input logic [4:0] o, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk_i);
        cmd_o <= '{valid: 1'b1, write: w, offset: o, wdata: d};
        @(posedge clk_i);
        cmd_o.valid <= 1'b0;
        // A missing answer reads as unknown so no compare can pass on it
        #1 q = rsp_valid_i ? rsp_data_i : 8'hxx;
    endtask

    task automatic adopt();
        @(posedge clk_i);
        addr_chg_o <= 1'b1;
        @(posedge clk_i);
        addr_chg_o <= 1'b0;
    endtask
endmodule

// [test/sensor_parameter_bank_tb.sv]
// Self-checking bench of the sensor parameter bank
`timescale 1ns/1ps
module sensor_parameter_bank_tb;
    logic core_clk_i, rst_i, addr_chg, meas_active, rsp_valid, res_valid;
    logic aux_en, ir_en, vis_en, p3_en, p2_en, p1_en;
    logic [7:0]  rsp_data, act_addr, q, e12, e3, pa, aa, ad;
    logic [2:0]  emit;
    logic [15:0] res_data;
    logic [16:0] d17;
    sensor_parameter_bank_pkg::param_cmd_t   cmd;
    sensor_parameter_bank_pkg::conv_chan_t   meas_chan, res_chan;
    sensor_parameter_bank_pkg::conv_sample_t sample;
    int mismatches, n_compared;
    logic [4:0] ofs [13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h19,
                             5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f};

    sensor_parameter_bank sensor_parameter_bank_i (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .param_cmd_i(cmd),
        .address_change_command_i(addr_chg), .meas_active_i(meas_active),
        .meas_chan_i(meas_chan), .conv_sample_i(sample), .rsp_valid_o(rsp_valid),
        .rsp_data_o(rsp_data), .active_bus_address_o(act_addr), .aux_enable_o(aux_en),
        .infrared_ambient_enable_o(ir_en), .visible_ambient_enable_o(vis_en),
        .proximity_three_enable_o(p3_en), .proximity_two_enable_o(p2_en),
        .proximity_one_enable_o(p1_en), .infrared_emitter_o(emit),
        .result_valid_o(res_valid), .result_chan_o(res_chan), .result_data_o(res_data));

    param_host param_host_i (.clk_i(core_clk_i), .rsp_valid_i(rsp_valid),
        .rsp_data_i(rsp_data), .cmd_o(cmd), .addr_chg_o(addr_chg));

    function automatic logic [7:0] wmask(input logic [4:0] o);
        case (o)
            5'h01, 5'h02: return 8'h77;
            5'h03:        return 8'h07;
            5'h05, 5'h1d: return 8'h70;
            5'h06:        return 8'h30;
            5'h1f:        return 8'h20;
            default:      return 8'hff;
        endcase
    endfunction

    function automatic logic [15:0] res_exp(input int c, input logic [16:0] d);
        logic b;
        b = c == 0 ? pa[4] : c == 1 ? pa[5] : c == 2 ? pa[6] : c == 3 ? aa[5] :
            c == 4 ? aa[4] : 1'b0;
        return b ? d[15:0] : d[16:1];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic emit_run();
        for (int c = 0; c < 7; c++) begin
            @(posedge core_clk_i);
            meas_active <= c < 6;
            meas_chan <= sensor_parameter_bank_pkg::conv_chan_t'(c % 6);
            @(posedge core_clk_i);
            #1 chk(emit, c == 0 ? e12[2:0] : c == 1 ? e12[6:4] : c == 2 ? e3[2:0] : 3'h0);
        end
    endtask

    task automatic res_run(input int n);
        for (int c = 0; c < 6; c++) begin
            d17 = n == 0 ? 17'h1_0001 : 17'($urandom);
            @(posedge core_clk_i);
            sample <= '{1'b1, sensor_parameter_bank_pkg::conv_chan_t'(c), d17};
            @(posedge core_clk_i);
            sample.valid <= 1'b0;
            #1 chk({res_valid, res_chan, res_data}, {1'b1, 3'(c), res_exp(c, d17)});
        end
    endtask

    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    // Whole run needs about 730 cycles; over twenty-five times that means a hang
    initial begin
        repeat (20000) @(posedge core_clk_i);
        mismatches++;
        end_sim();
    end

    initial begin
        mismatches = 0;
        n_compared = 0;
        rst_i = 1'b1;
        meas_active = 1'b0;
        meas_chan = sensor_parameter_bank_pkg::CHAN_PROX_ONE;
        sample = '0;
        void'($urandom(5443));
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1 chk({act_addr, aux_en, ir_en, vis_en, p3_en, p2_en, p1_en, emit}, 0);
        foreach (ofs[i]) begin
            param_host_i.xfer(1'b0, ofs[i], 8'h00, q);
            chk(q, ofs[i] == 5'h02 ? 8'h21 : ofs[i] == 5'h03 ? 8'h04 : 8'h00);
        end
        e12 = 8'h21;
        e3 = 8'h04;
        emit_run();
        for (int n = 0; n < 8; n++) begin
            foreach (ofs[i]) if (ofs[i] != 5'h1b) begin
                // Reserved bits are sent as zero, reserved entries never written
                ad = 8'($urandom) & wmask(ofs[i]);
                param_host_i.xfer(1'b1, ofs[i], ad, q);
                param_host_i.xfer(1'b0, ofs[i], 8'h00, q);
                chk(q, ad);
            end
            e12 = n == 0 ? 8'h70 : 8'($urandom) & 8'h77;
            e3 = n == 0 ? 8'h07 : 8'($urandom) & 8'h07;
            pa = n == 0 ? 8'h70 : 8'($urandom) & 8'h70;
            aa = n == 0 ? 8'h30 : 8'($urandom) & 8'h30;
            ad = 8'($urandom) & 8'h77;
            if (ad == 8'h00)
                ad = 8'h40; // Channel list is never left empty before measuring
            param_host_i.xfer(1'b1, 5'h02, e12, q);
            param_host_i.xfer(1'b1, 5'h03, e3, q);
            param_host_i.xfer(1'b1, 5'h05, pa, q);
            param_host_i.xfer(1'b1, 5'h06, aa, q);
            param_host_i.xfer(1'b1, 5'h01, ad, q);
            chk({aux_en, ir_en, vis_en, p3_en, p2_en, p1_en}, {ad[6:4], ad[2:0]});
            emit_run();
            res_run(n);
        end
        ad = 8'($urandom) | 8'h01;
        param_host_i.xfer(1'b1, 5'h00, ad, q);
        repeat (3) @(posedge core_clk_i);
        #1 chk(act_addr, 8'h00);
        param_host_i.adopt();
        #1 chk(act_addr, ad);
        end_sim();
    end
endmodule
